/* File: lms_pkg.sv */
// package: register map, field layout, timing constants and carrier types for the scan timing block
package lms_pkg;

    // ==========================================
    // clock and timing
    localparam int CLK_MHZ            = 25;
    localparam int PWM_FAST_NS        = 8000;
    localparam int PWM_SLOW_NS        = 16000;
    localparam int BLANK_LONG_NS      = 1000;
    localparam int BLANK_SHORT_NS     = 500;
    localparam int STAGGER_NS         = 125;
    localparam int CLK_PERIOD_NS      = 1000 / CLK_MHZ;
    // least times round up
    localparam int PWM_FAST_CYC       = (PWM_FAST_NS * CLK_MHZ + 999) / 1000;
    localparam int PWM_SLOW_CYC       = (PWM_SLOW_NS * CLK_MHZ + 999) / 1000;
    localparam int BLANK_LONG_CYC     = (BLANK_LONG_NS * CLK_MHZ + 999) / 1000;
    localparam int BLANK_SHORT_CYC    = (BLANK_SHORT_NS * CLK_MHZ + 999) / 1000;
    localparam int STAGGER_CYC        = (STAGGER_NS * CLK_MHZ + 999) / 1000;
    localparam int SINK_DELAY_CYC     = 1;
    localparam int CNT_W              = 10;

    // ==========================================
    // matrix geometry
    localparam int NUM_LINES          = 6;
    localparam int NUM_SINKS          = 18;
    localparam int NUM_GROUPS         = 3;

    // ==========================================
    // register offsets (byte addresses)
    localparam logic [7:0] ADDR_RUN      = 8'h00;
    localparam logic [7:0] ADDR_INIT     = 8'h04;
    localparam logic [7:0] ADDR_TIMING   = 8'h08;
    localparam logic [7:0] ADDR_COMP     = 8'h0C;
    localparam logic [7:0] ADDR_GHOST    = 8'h10;
    localparam logic [7:0] ADDR_STATUS   = 8'h14;

    // init register fields
    localparam int INIT_PWMSLOW_BIT   = 0;
    localparam int INIT_MODE_LSB      = 1;
    localparam int INIT_LINES_LSB     = 4;
    localparam int INIT_PEAK_LSB      = 8;
    // timing register fields
    localparam int TIM_BLANKSHORT_BIT = 0;
    localparam int TIM_STAGGER_BIT    = 1;
    localparam int TIM_SINKDLY_BIT    = 2;
    // ghost register fields
    localparam int GH_DISCH_BIT       = 0;
    localparam int GH_PRECH_LSB       = 4;
    // compensation fields, two bits each
    localparam int COMP_W             = 2;

    // ==========================================
    // reset values and peak code limit
    localparam logic [2:0] PEAK_RESET     = 3'h3;
    localparam logic [1:0] MODE_RESET     = 2'h1;
    localparam logic [2:0] LINES_RESET    = 3'h6;
    localparam logic [2:0] PEAK_MAX       = 3'h6;

    // ==========================================
    // types
    typedef enum logic [1:0] {
        LMS_IDLE  = 2'b00,
        LMS_BLANK = 2'b01,
        LMS_DELAY = 2'b10,
        LMS_SINK  = 2'b11
    } lms_state_t;

    typedef struct packed {
        logic       discharge;
        logic [1:0] precharge;
        logic [2:0] peak;
    } lms_analog_t;

endpackage

/* File: lms_scan_timing.sv */
// scan sequencer, blanking/de-ghost drive and peak current control with AXI4-Lite registers
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module lms_scan_timing (
    // clock and reset
    input  wire logic                               mclk,
    input  wire logic                               reset_n,
    // axi4-lite write address
    input  wire logic [7:0]                         s_axi_awaddr,
    input  wire logic                               s_axi_awvalid,
    output logic                                    s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]                        s_axi_wdata,
    input  wire logic [3:0]                         s_axi_wstrb,
    input  wire logic                               s_axi_wvalid,
    output logic                                    s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                              s_axi_bresp,
    output logic                                    s_axi_bvalid,
    input  wire logic                               s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]                         s_axi_araddr,
    input  wire logic                               s_axi_arvalid,
    output logic                                    s_axi_arready,
    output logic [31:0]                             s_axi_rdata,
    output logic [1:0]                              s_axi_rresp,
    output logic                                    s_axi_rvalid,
    input  wire logic                               s_axi_rready,
    // matrix drive
    output logic [lms_pkg::NUM_LINES-1:0]           lineOn,
    output logic [lms_pkg::NUM_LINES-1:0]           lineDischarge,
    output logic [lms_pkg::NUM_GROUPS-1:0]          sinkEnable,
    output logic                                    sinkPrecharge,
    output logic [1:0]                              prechargeLevel,
    output logic [2:0]                              peakCurrentCode,
    output logic [lms_pkg::NUM_SINKS*2-1:0]         sinkCompLevel,
    // frame data mode
    output logic                                    frameHoldMode,
    output logic                                    wideDataMode,
    output logic                                    subPeriodPulse
);

    // ==========================================
    // reset release
    logic rstSync1_ff;
    logic rstSync2_ff;
    logic rstN;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync1_ff <= 1'b0;
            rstSync2_ff <= 1'b0;
        end else begin
            rstSync1_ff <= 1'b1;
            rstSync2_ff <= rstSync1_ff;
        end
    end
    assign rstN = rstSync2_ff;

    // ==========================================
    // registers
    logic                            run_ff;
    logic                            pwmSlow_ff;
    logic [1:0]                      mode_ff;
    logic [2:0]                      lines_ff;
    logic [2:0]                      peakReq_ff;
    logic                            blankShort_ff;
    logic                            stagger_ff;
    logic                            sinkDelay_ff;
    logic [3*lms_pkg::COMP_W-1:0]    comp_ff;
    logic                            dischReq_ff;
    logic [1:0]                      prechReq_ff;
    lms_pkg::lms_analog_t            active_ff;
    lms_pkg::lms_analog_t            held_ff;

    // ==========================================
    // axi4-lite write channel
    logic [7:0] awAddr_ff;
    logic       awHeld_ff;
    logic [31:0] wData_ff;
    logic       wHeld_ff;
    logic       doWrite;

    assign s_axi_awready = !awHeld_ff && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_ff && !s_axi_bvalid;
    assign doWrite       = awHeld_ff && wHeld_ff;

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            awAddr_ff    <= 8'h00;
            awHeld_ff    <= 1'b0;
            wData_ff     <= 32'h00000000;
            wHeld_ff     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_ff <= s_axi_awaddr;
                awHeld_ff <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                // strobes apply to low byte lanes only; fields fit in bytes 0 and 1
                wData_ff <= {s_axi_wdata[31:16],
                             s_axi_wstrb[1] ? s_axi_wdata[15:8] : 8'h00,
                             s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00};
                wHeld_ff <= 1'b1;
            end
            if (doWrite) begin
                awHeld_ff    <= 1'b0;
                wHeld_ff     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addrKnown(awAddr_ff) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    function automatic logic addrKnown(input logic [7:0] a);
        addrKnown = (a == lms_pkg::ADDR_RUN) || (a == lms_pkg::ADDR_INIT) ||
                    (a == lms_pkg::ADDR_TIMING) || (a == lms_pkg::ADDR_COMP) ||
                    (a == lms_pkg::ADDR_GHOST) || (a == lms_pkg::ADDR_STATUS);
    endfunction

    logic wrRun;
    logic wrInit;
    logic wrTiming;
    logic wrComp;
    logic wrGhost;
    assign wrRun    = doWrite && (awAddr_ff == lms_pkg::ADDR_RUN);
    assign wrInit   = doWrite && (awAddr_ff == lms_pkg::ADDR_INIT);
    assign wrTiming = doWrite && (awAddr_ff == lms_pkg::ADDR_TIMING);
    assign wrComp   = doWrite && (awAddr_ff == lms_pkg::ADDR_COMP);
    assign wrGhost  = doWrite && (awAddr_ff == lms_pkg::ADDR_GHOST);

    // ==========================================
    // configuration storage
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            run_ff        <= 1'b0;
            pwmSlow_ff    <= 1'b0;
            mode_ff       <= lms_pkg::MODE_RESET;
            lines_ff      <= lms_pkg::LINES_RESET;
            peakReq_ff    <= lms_pkg::PEAK_RESET;
            blankShort_ff <= 1'b0;
            stagger_ff    <= 1'b0;
            sinkDelay_ff  <= 1'b0;
            comp_ff       <= '0;
            dischReq_ff   <= 1'b0;
            prechReq_ff   <= 2'h0;
        end else begin
            if (wrRun) begin
                run_ff <= wData_ff[0];
            end
            if (wrInit) begin
                pwmSlow_ff <= wData_ff[lms_pkg::INIT_PWMSLOW_BIT];
                // modes outside 1..3 are kept as mode 1
                mode_ff    <= (wData_ff[lms_pkg::INIT_MODE_LSB +: 2] == 2'h0) ? lms_pkg::MODE_RESET
                                                                               : wData_ff[lms_pkg::INIT_MODE_LSB +: 2];
                // line count clamps to 1..6
                if (wData_ff[lms_pkg::INIT_LINES_LSB +: 3] == 3'h0) begin
                    lines_ff <= 3'h1;
                end else if (wData_ff[lms_pkg::INIT_LINES_LSB +: 3] > lms_pkg::LINES_RESET) begin
                    lines_ff <= lms_pkg::LINES_RESET;
                end else begin
                    lines_ff <= wData_ff[lms_pkg::INIT_LINES_LSB +: 3];
                end
                peakReq_ff <= (wData_ff[lms_pkg::INIT_PEAK_LSB +: 3] > lms_pkg::PEAK_MAX) ? lms_pkg::PEAK_MAX
                                                                                           : wData_ff[lms_pkg::INIT_PEAK_LSB +: 3];
            end
            if (wrTiming) begin
                blankShort_ff <= wData_ff[lms_pkg::TIM_BLANKSHORT_BIT];
                stagger_ff    <= wData_ff[lms_pkg::TIM_STAGGER_BIT];
                sinkDelay_ff  <= wData_ff[lms_pkg::TIM_SINKDLY_BIT];
            end
            if (wrComp) begin
                comp_ff <= wData_ff[3*lms_pkg::COMP_W-1:0];
            end
            if (wrGhost) begin
                dischReq_ff <= wData_ff[lms_pkg::GH_DISCH_BIT];
                prechReq_ff <= wData_ff[lms_pkg::GH_PRECH_LSB +: 2];
            end
        end
    end

    // ==========================================
    // deferred analog update
    logic runPrev_ff;
    lms_pkg::lms_analog_t req;
    assign req = '{discharge: dischReq_ff, precharge: prechReq_ff, peak: peakReq_ff};

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            active_ff  <= '{discharge: 1'b0, precharge: 2'h0, peak: lms_pkg::PEAK_RESET};
            held_ff    <= '{discharge: 1'b0, precharge: 2'h0, peak: lms_pkg::PEAK_RESET};
            runPrev_ff <= 1'b0;
        end else begin
            runPrev_ff <= run_ff;
            if (mode_ff == lms_pkg::MODE_RESET) begin
                active_ff <= req;
                held_ff   <= req;
            end else begin
                if (!run_ff) begin
                    held_ff <= req;
                end
                if (run_ff && !runPrev_ff) begin
                    active_ff <= held_ff;
                end
            end
        end
    end

    // code passes straight to the current dac
    assign peakCurrentCode = active_ff.peak;
    assign prechargeLevel  = active_ff.precharge;
    // data update mode for the pwm path
    assign frameHoldMode   = (mode_ff != lms_pkg::MODE_RESET);
    assign wideDataMode    = (mode_ff == 2'h3);

    // compensation by sink index modulo three
    genvar gi;
    generate
        for (gi = 0; gi < lms_pkg::NUM_SINKS; gi++) begin : gComp
            assign sinkCompLevel[gi*2 +: 2] = comp_ff[(gi % 3)*lms_pkg::COMP_W +: lms_pkg::COMP_W];
        end
    endgenerate

    // ==========================================
    // scan sequencer
    localparam int CNT_W_L = lms_pkg::CNT_W;
    lms_pkg::lms_state_t state_ff;
    logic [CNT_W_L-1:0] cnt_ff;
    logic [2:0]         line_ff;

    logic [CNT_W_L-1:0] pwmCyc;
    logic [CNT_W_L-1:0] blankCyc;
    logic [CNT_W_L-1:0] stagCyc;
    // slot sink window covers active time plus both stagger steps
    logic [CNT_W_L-1:0] sinkCyc;
    assign pwmCyc   = pwmSlow_ff ? CNT_W_L'(lms_pkg::PWM_SLOW_CYC) : CNT_W_L'(lms_pkg::PWM_FAST_CYC);
    assign blankCyc = blankShort_ff ? CNT_W_L'(lms_pkg::BLANK_SHORT_CYC) : CNT_W_L'(lms_pkg::BLANK_LONG_CYC);
    assign stagCyc  = stagger_ff ? CNT_W_L'(lms_pkg::STAGGER_CYC) : CNT_W_L'(0);
    // delay carved from the sink window start
    assign sinkCyc  = CNT_W_L'(pwmCyc + stagCyc + stagCyc);

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            state_ff       <= lms_pkg::LMS_IDLE;
            cnt_ff         <= '0;
            line_ff        <= 3'h0;
            subPeriodPulse <= 1'b0;
        end else begin
            subPeriodPulse <= 1'b0;
            case (state_ff)
                lms_pkg::LMS_IDLE: begin
                    line_ff <= 3'h0;
                    cnt_ff  <= '0;
                    if (run_ff) begin
                        state_ff <= lms_pkg::LMS_BLANK;
                    end
                end
                lms_pkg::LMS_BLANK: begin
                    if (!run_ff) begin
                        state_ff <= lms_pkg::LMS_IDLE;
                    end else if (cnt_ff == CNT_W_L'(blankCyc - 1'b1)) begin
                        cnt_ff   <= '0;
                        state_ff <= sinkDelay_ff ? lms_pkg::LMS_DELAY : lms_pkg::LMS_SINK;
                    end else begin
                        cnt_ff <= CNT_W_L'(cnt_ff + 1'b1);
                    end
                end
                lms_pkg::LMS_DELAY: begin
                    // line on, sinks held off one clock
                    cnt_ff   <= CNT_W_L'(lms_pkg::SINK_DELAY_CYC);
                    state_ff <= run_ff ? lms_pkg::LMS_SINK : lms_pkg::LMS_IDLE;
                end
                lms_pkg::LMS_SINK: begin
                    if (!run_ff) begin
                        state_ff <= lms_pkg::LMS_IDLE;
                    end else if (cnt_ff >= CNT_W_L'(sinkCyc - 1'b1)) begin
                        cnt_ff   <= '0;
                        state_ff <= lms_pkg::LMS_BLANK;
                        if (line_ff >= 3'(lines_ff - 1'b1)) begin
                            line_ff        <= 3'h0;
                            subPeriodPulse <= 1'b1;
                        end else begin
                            line_ff <= 3'(line_ff + 1'b1);
                        end
                    end else begin
                        cnt_ff <= CNT_W_L'(cnt_ff + 1'b1);
                    end
                end
                default: begin
                    state_ff <= lms_pkg::LMS_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // drive outputs
    logic inSlot;
    logic inBlank;
    assign inSlot  = (state_ff == lms_pkg::LMS_DELAY) || (state_ff == lms_pkg::LMS_SINK);
    assign inBlank = (state_ff == lms_pkg::LMS_BLANK);

    generate
        for (gi = 0; gi < lms_pkg::NUM_LINES; gi++) begin : gLine
            assign lineOn[gi]        = inSlot && (line_ff == 3'(gi));
            assign lineDischarge[gi] = inBlank && active_ff.discharge;
        end
        for (gi = 0; gi < lms_pkg::NUM_GROUPS; gi++) begin : gPhase
            // groups staggered by one stagger step each
            assign sinkEnable[gi] = (state_ff == lms_pkg::LMS_SINK) &&
                                    (cnt_ff >= CNT_W_L'(stagCyc * gi)) &&
                                    (cnt_ff < CNT_W_L'(pwmCyc + stagCyc * gi));
        end
    endgenerate

    assign sinkPrecharge = inBlank;

    // ==========================================
    // read channel
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h00000000;
        if (s_axi_araddr == lms_pkg::ADDR_RUN) begin
            rdMux[0] = run_ff;
        end else if (s_axi_araddr == lms_pkg::ADDR_INIT) begin
            rdMux[lms_pkg::INIT_PWMSLOW_BIT]     = pwmSlow_ff;
            rdMux[lms_pkg::INIT_MODE_LSB +: 2]   = mode_ff;
            rdMux[lms_pkg::INIT_LINES_LSB +: 3]  = lines_ff;
            rdMux[lms_pkg::INIT_PEAK_LSB +: 3]   = peakReq_ff;
        end else if (s_axi_araddr == lms_pkg::ADDR_TIMING) begin
            rdMux[lms_pkg::TIM_BLANKSHORT_BIT] = blankShort_ff;
            rdMux[lms_pkg::TIM_STAGGER_BIT]    = stagger_ff;
            rdMux[lms_pkg::TIM_SINKDLY_BIT]    = sinkDelay_ff;
        end else if (s_axi_araddr == lms_pkg::ADDR_COMP) begin
            rdMux[3*lms_pkg::COMP_W-1:0] = comp_ff;
        end else if (s_axi_araddr == lms_pkg::ADDR_GHOST) begin
            rdMux[lms_pkg::GH_DISCH_BIT]      = dischReq_ff;
            rdMux[lms_pkg::GH_PRECH_LSB +: 2] = prechReq_ff;
        end else if (s_axi_araddr == lms_pkg::ADDR_STATUS) begin
            rdMux[2:0]   = line_ff;
            rdMux[5:4]   = state_ff;
            rdMux[10:8]  = active_ff.peak;
            rdMux[12]    = active_ff.discharge;
            rdMux[14:13] = active_ff.precharge;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'h0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdMux;
                s_axi_rresp  <= addrKnown(s_axi_araddr) ? 2'h0 : 2'h2;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

/* File: lms_scan_checker_assertions.sv */
// checker: scan order, blanking and peak code relations at the ports
`timescale 1ns/1ps
`default_nettype none
module lms_scan_checker (
    // clock and reset
    input wire logic        mclk,
    input wire logic        reset_n,
    // matrix drive
    input wire logic [5:0]  lineOn,
    input wire logic [5:0]  lineDischarge,
    input wire logic [2:0]  sinkEnable,
    input wire logic        sinkPrecharge,
    input wire logic [2:0]  peakCurrentCode,
    input wire logic [35:0] sinkCompLevel,
    input wire logic        subPeriodPulse
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // ====================
    // port relations
    a_line_onehot: assert property ($onehot0(lineOn))
        else $error("several scan lines on");
    // last line shown, for the order check
    logic [5:0] lastOn_ff;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lastOn_ff <= 6'h00;
        end else if (|lineOn) begin
            lastOn_ff <= lineOn;
        end
    end
    a_line_ascend: assert property (!(|$past(lineOn)) && (|lineOn)
        |-> lineOn == 6'(lastOn_ff << 1) || lineOn == 6'h01) else $error("scan line out of order");
    a_sink_line: assert property ((|sinkEnable) |-> (|lineOn))
        else $error("sink on without line");
    a_disch_blank: assert property ((|lineDischarge) |-> sinkPrecharge && lineDischarge == 6'h3F)
        else $error("discharge outside blank");
    a_prech_excl: assert property (sinkPrecharge |-> sinkEnable == 3'h0)
        else $error("precharge while sinking");
    a_peak_range: assert property (peakCurrentCode <= 3'h6)
        else $error("peak code above range");
    a_comp_groups: assert property (sinkCompLevel == {6{sinkCompLevel[5:0]}})
        else $error("comp group mismatch");
    a_stagger_order: assert property ($rose(sinkEnable[2]) |-> sinkEnable[0])
        else $error("phase order wrong");
    cover property (subPeriodPulse);
    cover property (|lineDischarge);
    cover property (sinkEnable == 3'h1);
endmodule
bind lms_scan_timing lms_scan_checker u_chk (.mclk, .reset_n, .lineOn, .lineDischarge, .sinkEnable, .sinkPrecharge,
    .peakCurrentCode, .sinkCompLevel, .subPeriodPulse);
`default_nettype wire

/* File: lms_matrix_model.sv */
// partner model: matrix load timing the slots and sub-periods it sees
`timescale 1ns/1ps
`default_nettype none
module lms_matrix_model (
    // matrix drive
    input wire logic        mclk,
    input wire logic [5:0]  lineOn,
    input wire logic        subPeriodPulse,
    // measured spans in cycles
    output logic [31:0]     slotLen,
    output logic [31:0]     subLen
);
    logic [5:0]  prevOn_ff = 6'h00;
    logic [31:0] slotCnt_ff = 32'h0;
    logic [31:0] subCnt_ff = 32'h0;
    // ====================
    // line onset to next onset
    always_ff @(posedge mclk) begin
        prevOn_ff <= lineOn;
        slotCnt_ff <= (lineOn != 6'h00 && lineOn != prevOn_ff) ? 32'h1 : slotCnt_ff + 32'h1;
        if (lineOn != 6'h00 && lineOn != prevOn_ff) begin
            slotLen <= slotCnt_ff;
        end
    end
    // pulse to pulse
    always_ff @(posedge mclk) begin
        subCnt_ff <= subPeriodPulse ? 32'h1 : subCnt_ff + 32'h1;
        if (subPeriodPulse) begin
            subLen <= subCnt_ff;
        end
    end
endmodule
`default_nettype wire

/* File: led_matrix_scan_timing_bench.sv */
// bench: register-driven scan timing and peak code checks
`timescale 1ns/1ps
`default_nettype none
module led_matrix_scan_timing_bench;
    logic        mclk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sinkPrecharge, frameHoldMode, wideDataMode;
    logic        subPeriodPulse;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, slotLen, subLen, rdat;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, prechargeLevel, rrsp;
    logic [5:0]  lineOn, lineDischarge;
    logic [2:0]  sinkEnable, peakCurrentCode;
    logic [35:0] sinkCompLevel;
    int          miscompares = 0;
    int          testsRun = 0;
    lms_scan_timing dut (.mclk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lineOn, .lineDischarge, .sinkEnable,
        .sinkPrecharge, .prechargeLevel, .peakCurrentCode, .sinkCompLevel, .frameHoldMode, .wideDataMode,
        .subPeriodPulse);
    lms_matrix_model load (.mclk, .lineOn, .subPeriodPulse, .slotLen, .subLen);
    // ====================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic closeOut;
        if (miscompares == 0 && testsRun > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        rrsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic waitPulse;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (!subPeriodPulse && n < 20000);
    endtask
    task automatic scan(input logic [31:0] init, input logic [31:0] tim, input int lines, input int slot);
        wr(lms_pkg::ADDR_RUN, 32'h0);
        wr(lms_pkg::ADDR_INIT, 32'h302 | init | 32'(lines) << 4);
        wr(lms_pkg::ADDR_TIMING, tim);
        wr(lms_pkg::ADDR_RUN, 32'h1);
        waitPulse();
        waitPulse();
        @(posedge mclk);
        chk(slotLen, 32'(slot));
        chk(subLen, 32'(slot * lines));
    endtask
    // ====================
    // stimulus
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        #2400000;
        miscompares++;
        closeOut;
    end
    initial begin
        {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(32'(peakCurrentCode), 32'(lms_pkg::PEAK_RESET));
        rd(8'h18);
        chk(rdat, 32'h0);
        chk(32'(rrsp), 32'h2);
        for (int c = 0; c < 8; c++) begin
            wr(lms_pkg::ADDR_INIT, 32'h062 | 32'(c) << 8);
            @(posedge mclk);
            chk(32'(peakCurrentCode), 32'(c > 6 ? 6 : c));
        end
        wr(lms_pkg::ADDR_COMP, 32'h39);
        wr(lms_pkg::ADDR_GHOST, 32'h21);
        @(posedge mclk);
        chk(32'(sinkCompLevel[5:0]), 32'h39);
        chk(32'(prechargeLevel), 32'h2);
        s_axi_wstrb <= 4'h2;
        wr(lms_pkg::ADDR_COMP, 32'h3F);
        s_axi_wstrb <= 4'hF;
        rd(lms_pkg::ADDR_COMP);
        chk(rdat, 32'h0);
        wr(lms_pkg::ADDR_GHOST, 32'h01);
        scan(32'h0, 32'h0, 6, lms_pkg::BLANK_LONG_CYC + lms_pkg::PWM_FAST_CYC);
        scan(32'h0, 32'h1, 3, lms_pkg::BLANK_SHORT_CYC + lms_pkg::PWM_FAST_CYC);
        scan(32'h0, 32'h2, 2, lms_pkg::BLANK_LONG_CYC + lms_pkg::PWM_FAST_CYC + 2 * lms_pkg::STAGGER_CYC);
        scan(32'h1, 32'h4, 6, lms_pkg::BLANK_LONG_CYC + lms_pkg::PWM_SLOW_CYC);
        do @(posedge mclk); while (lineOn != 6'h00);
        do @(posedge mclk); while (lineOn == 6'h00);
        chk(32'(sinkEnable), 32'h0);
        @(posedge mclk);
        chk(32'(sinkEnable), 32'h7);
        for (int m = 2; m < 4; m++) begin
            wr(lms_pkg::ADDR_RUN, 32'h0);
            wr(lms_pkg::ADDR_INIT, 32'h060 | 32'(m + 1) << 8 | 32'(m) << 1);
            wr(lms_pkg::ADDR_INIT, 32'h060 | 32'(m + 2) << 8 | 32'(m) << 1);
            wr(lms_pkg::ADDR_GHOST, 32'h01 | 32'(m - 1) << 4);
            @(posedge mclk);
            chk(32'(peakCurrentCode), 32'(m + 1));
            chk(32'(prechargeLevel), 32'(m - 2));
            wr(lms_pkg::ADDR_RUN, 32'h1);
            @(posedge mclk);
            chk(32'(peakCurrentCode), 32'(m + 2));
            chk(32'(prechargeLevel), 32'(m - 1));
            chk({30'h0, frameHoldMode, wideDataMode}, 32'(m));
        end
        closeOut;
    end
endmodule
`default_nettype wire
